//--- hdl/oag_top.sv
// Operand and branch-target address generator with the system stack pointer.
// Assumes a register file and program memory that return read data one cycle after the read.
//
// How it works
// - Stack pointer lives at register location D9H and addresses every push and pop.
// - Stack pointer has no reset value; contents are unknown until software writes it.
// - Push decrements then writes; pop reads then increments.
// - Seven addressing modes, each instruction allowed only its own subset.
// - Register mode takes the operand from the named register or register pair.
// - Working registers use a pointer to pick an 8-byte window, then one register.
// - Top bit picks pointer zero or one; five pointer bits join three address bits.
// - Register pairs start at an even address, high byte even, low byte odd.
// - Indirect register uses register contents as the address into the right space.
// - Any register points to a register; any pair points into memory.
// - Indirect register addressing cannot reach locations C0H to FFH.
// - Indexed adds offset to base and cannot reach locations C0H to FFH.
// - Short indexed offsets are signed, -128 to +127.
// - Indexed register access adds instruction base to working register offset.
// - Indexed memory access adds instruction offset to a working register pair base.
// - Only plain load indexes the register file; the two memory loads index memory.
// - Direct mode carries a 16-bit address, loaded into the PC for jump and call.
// - Memory loads accept a direct 16-bit address as source or destination.
// - Indirect address mode forces the upper byte to zero: lowest 256 program bytes.
// - Indirect address mode reads two program bytes as the next instruction address.
// - Indirect address mode is decoded only for the call instruction.
// - Relative mode adds a signed -128 to +127 displacement to the PC.
// - The PC already points past the current instruction when the displacement adds.
// - Relative mode serves the two bit tests, decrement branch, compare branches, jump.
`timescale 1ns/1ps
`include "oag_regs.svh"

module oag_top
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic req_valid,
	output logic req_ready,
	input wire oag_pkg::oag_mode_t req_mode,
	input wire oag_pkg::oag_instr_t req_instr,
	input wire logic [7:0] req_reg,
	input wire logic req_work4,
	input wire logic req_pair,
	input wire logic req_short,
	input wire logic [15:0] req_operand,
	input wire logic [15:0] req_pc,
	input wire logic [2:0] req_length,
	input wire logic [7:0] register_pointer_zero,
	input wire logic [7:0] register_pointer_one,
	output logic rf_rd_en,
	output logic [7:0] rf_rd_addr,
	input wire logic [7:0] rf_rd_data,
	input wire logic rf_wr_en,
	input wire logic [7:0] rf_wr_addr,
	input wire logic [7:0] rf_wr_data,
	output logic [7:0] sp_rd_data,
	output logic pm_rd_en,
	output logic [15:0] pm_rd_addr,
	input wire logic [7:0] pm_rd_data,
	output logic ea_valid,
	output logic [15:0] ea_addr,
	output oag_pkg::oag_space_t ea_space,
	output logic ea_error,
	input wire logic stack_push,
	input wire logic stack_pop,
	output logic [7:0] stack_addr
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ****************************************
	// Stack pointer
	// ****************************************
	logic [7:0] stack_pointer;
	logic sp_load;

	assign sp_load = rf_wr_en && (rf_wr_addr == `OAG_SP_ADDR);
	assign sp_rd_data = stack_pointer;

	// no reset value
	// The pointer is deliberately left out of the reset so that nothing relies on a value.
	// A software write wins over a push or pop in the same cycle.
	always_ff @(posedge clk)
	begin
		if (sp_load)
			stack_pointer <= rf_wr_data;
		else if (stack_push)
			stack_pointer <= stack_pointer - `OAG_SP_STEP;
		else if (stack_pop)
			stack_pointer <= stack_pointer + `OAG_SP_STEP;
	end

	// push writes below, pop reads at
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stack_addr <= 8'h00;
		else if (stack_push && !sp_load)
			stack_addr <= stack_pointer - `OAG_SP_STEP;
		else if (stack_pop && !sp_load)
			stack_addr <= stack_pointer;
	end

	// ****************************************
	// Request decode
	// ****************************************
	typedef enum logic [1:0] {OAG_ST_IDLE, OAG_ST_ISSUE, OAG_ST_CAPTURE, OAG_ST_FINISH} oag_state_t;

	oag_state_t state;
	logic [7:0] reg_addr;
	logic mode_ok;
	logic is_branch;
	logic is_mem_load;
	logic needs_fetch;
	logic fetch_two;
	logic fetch_pm;
	logic [15:0] fetch_start;
	logic odd_pair;
	logic [15:0] next_pc;

	assign req_ready = (state == OAG_ST_IDLE);

	always_comb
	begin
		if (req_work4 || (req_reg[7:4] == `OAG_WREG_PREFIX))
		begin
			if (req_reg[`OAG_WREG_SEL_BIT])
				reg_addr = {register_pointer_one[`OAG_RP_SLICE_MSB:`OAG_RP_SLICE_LSB], req_reg[2:0]};
			else
				reg_addr = {register_pointer_zero[`OAG_RP_SLICE_MSB:`OAG_RP_SLICE_LSB], req_reg[2:0]};
		end
		else
			reg_addr = req_reg;
	end

	assign is_branch = (req_instr == oag_pkg::OAG_INSTR_SHORT_RELATIVE_JUMP) ||
		(req_instr == oag_pkg::OAG_INSTR_BIT_TEST_BRANCH_IF_FALSE) ||
		(req_instr == oag_pkg::OAG_INSTR_BIT_TEST_BRANCH_IF_TRUE) ||
		(req_instr == oag_pkg::OAG_INSTR_DECREMENT_BRANCH_NONZERO) ||
		(req_instr == oag_pkg::OAG_INSTR_COMPARE_INCREMENT_BRANCH_EQUAL) ||
		(req_instr == oag_pkg::OAG_INSTR_COMPARE_INCREMENT_BRANCH_UNEQUAL);
	assign is_mem_load = (req_instr == oag_pkg::OAG_INSTR_PROGRAM_MEMORY_LOAD) ||
		(req_instr == oag_pkg::OAG_INSTR_EXTERNAL_DATA_LOAD);

	always_comb
	begin
		unique case (req_mode)
			oag_pkg::OAG_MODE_REGISTER: mode_ok = 1'b1;
			oag_pkg::OAG_MODE_INDIRECT_REGISTER: mode_ok = 1'b1;
			oag_pkg::OAG_MODE_IMMEDIATE: mode_ok = 1'b1;
			oag_pkg::OAG_MODE_INDEXED: mode_ok = is_mem_load ||
				(req_instr == oag_pkg::OAG_INSTR_PLAIN_LOAD);
			oag_pkg::OAG_MODE_DIRECT: mode_ok = is_mem_load ||
				(req_instr == oag_pkg::OAG_INSTR_ABSOLUTE_JUMP) ||
				(req_instr == oag_pkg::OAG_INSTR_CALL);
			oag_pkg::OAG_MODE_INDIRECT_ADDRESS: mode_ok = (req_instr == oag_pkg::OAG_INSTR_CALL);
			oag_pkg::OAG_MODE_RELATIVE: mode_ok = is_branch;
			default: mode_ok = 1'b0;
		endcase
	end

	assign odd_pair = reg_addr[0] && (req_pair || ((req_mode == oag_pkg::OAG_MODE_INDEXED) &&
		(req_instr != oag_pkg::OAG_INSTR_PLAIN_LOAD)));

	always_comb
	begin
		needs_fetch = 1'b0;
		fetch_two = 1'b0;
		fetch_pm = 1'b0;
		fetch_start = {8'h00, reg_addr};
		if (req_mode == oag_pkg::OAG_MODE_INDIRECT_REGISTER)
		begin
			needs_fetch = 1'b1;
			fetch_two = req_pair;
		end
		else if (req_mode == oag_pkg::OAG_MODE_INDEXED)
		begin
			needs_fetch = 1'b1;
			fetch_two = (req_instr != oag_pkg::OAG_INSTR_PLAIN_LOAD);
		end
		else if (req_mode == oag_pkg::OAG_MODE_INDIRECT_ADDRESS)
		begin
			needs_fetch = 1'b1;
			fetch_two = 1'b1;
			fetch_pm = 1'b1;
			fetch_start = {`OAG_IA_PAGE, req_operand[7:0]};
		end
	end

	assign next_pc = req_pc + {13'h0000, req_length};

	// ****************************************
	// Sequencer
	// ****************************************
	oag_pkg::oag_mode_t cur_mode;
	oag_pkg::oag_instr_t cur_instr;
	logic cur_pair;
	logic cur_short;
	logic cur_bad;
	logic cur_two;
	logic cur_pm;
	logic fetch_idx;
	logic [7:0] cur_reg;
	logic [15:0] cur_operand;
	logic [15:0] cur_next_pc;
	logic [15:0] fetch_addr;
	logic [15:0] data16;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= OAG_ST_IDLE;
		else
		begin
			unique case (state)
				OAG_ST_IDLE:
					if (req_valid)
						state <= (needs_fetch && mode_ok && !odd_pair) ? OAG_ST_ISSUE : OAG_ST_FINISH;
				OAG_ST_ISSUE: state <= OAG_ST_CAPTURE;
				OAG_ST_CAPTURE: state <= (cur_two && !fetch_idx) ? OAG_ST_ISSUE : OAG_ST_FINISH;
				OAG_ST_FINISH: state <= OAG_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_mode <= oag_pkg::OAG_MODE_IMMEDIATE;
			cur_instr <= oag_pkg::OAG_INSTR_OTHER;
			cur_pair <= 1'b0;
			cur_short <= 1'b0;
			cur_bad <= 1'b0;
			cur_two <= 1'b0;
			cur_pm <= 1'b0;
			cur_reg <= 8'h00;
			cur_operand <= 16'h0000;
			cur_next_pc <= 16'h0000;
		end
		else if ((state == OAG_ST_IDLE) && req_valid)
		begin
			cur_mode <= req_mode;
			cur_instr <= req_instr;
			cur_pair <= req_pair;
			cur_short <= req_short;
			cur_bad <= !mode_ok || odd_pair;
			cur_two <= fetch_two;
			cur_pm <= fetch_pm;
			cur_reg <= reg_addr;
			cur_operand <= req_operand;
			cur_next_pc <= next_pc;
		end
	end

	// high byte first from the even address
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_addr <= 16'h0000;
			fetch_idx <= 1'b0;
			data16 <= 16'h0000;
		end
		else if ((state == OAG_ST_IDLE) && req_valid)
		begin
			fetch_addr <= fetch_start;
			fetch_idx <= 1'b0;
			data16 <= 16'h0000;
		end
		else if (state == OAG_ST_CAPTURE)
		begin
			data16 <= {data16[7:0], cur_pm ? pm_rd_data : rf_rd_data};
			fetch_addr <= fetch_addr + `OAG_BYTE_STEP;
			fetch_idx <= 1'b1;
		end
	end

	// program memory reads for the table entry
	assign pm_rd_en = (state == OAG_ST_ISSUE) && cur_pm;
	assign pm_rd_addr = fetch_addr;
	assign rf_rd_en = (state == OAG_ST_ISSUE) && !cur_pm;
	assign rf_rd_addr = fetch_addr[7:0];

	// ****************************************
	// Effective address
	// ****************************************
	logic [15:0] next_ea;
	oag_pkg::oag_space_t next_space;
	logic next_err;
	logic [15:0] index_offset;
	logic [7:0] reg_sum;
	oag_pkg::oag_space_t mem_space;

	assign index_offset = cur_short ? {{8{cur_operand[7]}}, cur_operand[7:0]} : cur_operand;
	assign reg_sum = cur_operand[7:0] + data16[7:0];
	assign mem_space = (cur_instr == oag_pkg::OAG_INSTR_EXTERNAL_DATA_LOAD) ?
		oag_pkg::OAG_SPACE_EXTERNAL : oag_pkg::OAG_SPACE_PROGRAM;

	always_comb
	begin
		next_ea = 16'h0000;
		next_space = oag_pkg::OAG_SPACE_NONE;
		next_err = cur_bad;
		unique case (cur_mode)
			oag_pkg::OAG_MODE_REGISTER:
			begin
				next_ea = {8'h00, cur_reg};
				next_space = oag_pkg::OAG_SPACE_REGISTER;
			end
			oag_pkg::OAG_MODE_INDIRECT_REGISTER:
			begin
				if (cur_pair)
				begin
					next_ea = data16;
					next_space = mem_space;
				end
				else
				begin
					next_ea = {8'h00, data16[7:0]};
					next_space = oag_pkg::OAG_SPACE_REGISTER;
					next_err = cur_bad || (data16[7:0] >= `OAG_SET_ONE_BASE);
				end
			end
			oag_pkg::OAG_MODE_INDEXED:
			begin
				if (cur_instr == oag_pkg::OAG_INSTR_PLAIN_LOAD)
				begin
					next_ea = {8'h00, reg_sum};
					next_space = oag_pkg::OAG_SPACE_REGISTER;
					next_err = cur_bad || (reg_sum >= `OAG_SET_ONE_BASE);
				end
				else
				begin
					next_ea = data16 + index_offset;
					next_space = mem_space;
				end
			end
			// full address, PC target for jump and call
			oag_pkg::OAG_MODE_DIRECT:
			begin
				next_ea = cur_operand;
				next_space = ((cur_instr == oag_pkg::OAG_INSTR_ABSOLUTE_JUMP) ||
					(cur_instr == oag_pkg::OAG_INSTR_CALL)) ? oag_pkg::OAG_SPACE_PC : mem_space;
			end
			oag_pkg::OAG_MODE_INDIRECT_ADDRESS:
			begin
				next_ea = data16;
				next_space = oag_pkg::OAG_SPACE_PC;
			end
			// signed displacement onto the following address
			oag_pkg::OAG_MODE_RELATIVE:
			begin
				next_ea = cur_next_pc + {{8{cur_operand[7]}}, cur_operand[7:0]};
				next_space = oag_pkg::OAG_SPACE_PC;
			end
			oag_pkg::OAG_MODE_IMMEDIATE:
			begin
				next_ea = cur_operand;
				next_space = oag_pkg::OAG_SPACE_NONE;
			end
			default:
			begin
				next_err = 1'b1;
			end
		endcase
		if (next_err)
			next_space = oag_pkg::OAG_SPACE_NONE;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ea_valid <= 1'b0;
			ea_error <= 1'b0;
			ea_addr <= 16'h0000;
			ea_space <= oag_pkg::OAG_SPACE_NONE;
		end
		else
		begin
			ea_valid <= (state == OAG_ST_FINISH);
			ea_error <= (state == OAG_ST_FINISH) && next_err;
			if (state == OAG_ST_FINISH)
			begin
				ea_addr <= next_ea;
				ea_space <= next_space;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_push_decrement: assert property (@(posedge clk) disable iff (!rst_n)
		stack_push && !sp_load |=> stack_addr == $past(stack_pointer) - 8'h01 &&
		stack_pointer == stack_addr) else $error("push did not pre-decrement");
	a_pop_increment: assert property (@(posedge clk) disable iff (!rst_n)
		stack_pop && !stack_push && !sp_load |=> stack_addr == $past(stack_pointer) &&
		stack_pointer == stack_addr + 8'h01) else $error("pop did not post-increment");
	a_sp_write: assert property (@(posedge clk) disable iff (!rst_n)
		rf_wr_en && rf_wr_addr == 8'hd9 |=> sp_rd_data == $past(rf_wr_data))
		else $error("stack pointer write lost");
	a_ia_call_only: assert property (@(posedge clk) disable iff (!rst_n)
		req_ready && req_valid && req_mode == oag_pkg::OAG_MODE_INDIRECT_ADDRESS &&
		req_instr != oag_pkg::OAG_INSTR_CALL |=> ##1 ea_valid && ea_error)
		else $error("indirect address accepted outside call");
	a_ia_low_page: assert property (@(posedge clk) disable iff (!rst_n)
		pm_rd_en && !fetch_idx |-> pm_rd_addr[15:8] == 8'h00 ##2 pm_rd_en)
		else $error("indirect table read left the low page or missed its second byte");
	a_rel_target: assert property (@(posedge clk) disable iff (!rst_n)
		req_ready && req_valid && req_mode == oag_pkg::OAG_MODE_RELATIVE &&
		req_instr == oag_pkg::OAG_INSTR_SHORT_RELATIVE_JUMP |=> ##1 ea_valid && !ea_error &&
		ea_addr == $past(req_pc, 2) + $past(req_length, 2) +
		{{8{$past(req_operand[7], 2)}}, $past(req_operand[7:0], 2)})
		else $error("relative target wrong");
	a_set_one_block: assert property (@(posedge clk) disable iff (!rst_n)
		ea_valid && ea_space == oag_pkg::OAG_SPACE_REGISTER &&
		$past(cur_mode) != oag_pkg::OAG_MODE_REGISTER |-> ea_addr[7:0] < 8'hc0)
		else $error("set-one location reached indirectly");
	a_wreg_compose: assert property (@(posedge clk) disable iff (!rst_n)
		req_ready && req_valid && req_work4 && req_mode == oag_pkg::OAG_MODE_REGISTER &&
		!req_reg[3] |=> ##1 ea_addr[7:0] == {$past(register_pointer_zero[7:3], 2),
		$past(req_reg[2:0], 2)}) else $error("working register address wrong");
	a_fetch_bounded: assert property (@(posedge clk) disable iff (!rst_n)
		req_ready && req_valid |-> ##[1:6] ea_valid) else $error("address never produced");

endmodule : oag_top

//--- inc/oag_pkg.sv
// Types shared by the operand address generator and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package oag_pkg;

	// Explicit operand addressing modes.
	typedef enum logic [2:0] {
		OAG_MODE_REGISTER,
		OAG_MODE_INDIRECT_REGISTER,
		OAG_MODE_INDEXED,
		OAG_MODE_DIRECT,
		OAG_MODE_INDIRECT_ADDRESS,
		OAG_MODE_RELATIVE,
		OAG_MODE_IMMEDIATE
	} oag_mode_t;

	// Instruction classes that decide which modes are legal.
	typedef enum logic [3:0] {
		OAG_INSTR_PLAIN_LOAD,
		OAG_INSTR_PROGRAM_MEMORY_LOAD,
		OAG_INSTR_EXTERNAL_DATA_LOAD,
		OAG_INSTR_ABSOLUTE_JUMP,
		OAG_INSTR_CALL,
		OAG_INSTR_SHORT_RELATIVE_JUMP,
		OAG_INSTR_BIT_TEST_BRANCH_IF_FALSE,
		OAG_INSTR_BIT_TEST_BRANCH_IF_TRUE,
		OAG_INSTR_DECREMENT_BRANCH_NONZERO,
		OAG_INSTR_COMPARE_INCREMENT_BRANCH_EQUAL,
		OAG_INSTR_COMPARE_INCREMENT_BRANCH_UNEQUAL,
		OAG_INSTR_OTHER
	} oag_instr_t;

	// Space that an effective address points into.
	typedef enum logic [2:0] {
		OAG_SPACE_NONE,
		OAG_SPACE_REGISTER,
		OAG_SPACE_PROGRAM,
		OAG_SPACE_EXTERNAL,
		OAG_SPACE_PC
	} oag_space_t;

endpackage : oag_pkg

//--- inc/oag_regs.svh
// Register locations, address constants and field positions of the operand address generator.
// Assumes it is included by bare name wherever these values are needed.
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH

// Register-file location of the stack pointer.
`define OAG_SP_ADDR 8'hd9
// First location of the set-one area that indirect and indexed modes cannot reach.
`define OAG_SET_ONE_BASE 8'hc0
// Upper nibble that marks an 8-bit register field as a working register reference.
`define OAG_WREG_PREFIX 4'hc
// Upper byte forced onto an indirect-address table location.
`define OAG_IA_PAGE 8'h00
// Field positions inside a working register reference and a register pointer.
`define OAG_WREG_SEL_BIT 3
`define OAG_RP_SLICE_MSB 7
`define OAG_RP_SLICE_LSB 3
// Step of the stack pointer on each push or pop.
`define OAG_SP_STEP 8'h01
// Step between the two bytes of a pair or an indirect-address table entry.
`define OAG_BYTE_STEP 16'h0001

`endif

//--- test/oag_mem_model.sv
// Partner model: register file and program memory behind the address generator.
// Assumes each read is answered on the cycle after its enable is sampled.
`timescale 1ns/1ps

module oag_mem_model
(
	input wire logic clk,
	input wire logic rf_rd_en,
	input wire logic [7:0] rf_rd_addr,
	output logic [7:0] rf_rd_data,
	input wire logic pm_rd_en,
	input wire logic [15:0] pm_rd_addr,
	output logic [7:0] pm_rd_data
);
	// ****
	// Read answers
	// ****
	// Contents are a fixed function of the address, so the bench can predict every byte.
	// Between answers the data toggles, so a late capture cannot pass for a fresh one.
	initial
	begin
		rf_rd_data = 8'h00;
		pm_rd_data = 8'h00;
	end

	always @(posedge clk)
	begin
		if (rf_rd_en)
			rf_rd_data <= rf_rd_addr ^ 8'h80;
		else
			rf_rd_data <= ~rf_rd_data;
	end

	always @(posedge clk)
	begin
		if (pm_rd_en)
			pm_rd_data <= pm_rd_addr[7:0] ^ pm_rd_addr[15:8] ^ 8'h5a;
		else
			pm_rd_data <= ~pm_rd_data;
	end
endmodule : oag_mem_model

//--- test/test_operand_address_generator.sv
// Self-checking bench for the operand address generator and its stack pointer.
// Assumes the memory model answers reads one cycle late with address-derived bytes.
`timescale 1ns/1ps
`include "oag_regs.svh"

module test_operand_address_generator;
	// ****
	// Signals
	// ****
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready;
	oag_pkg::oag_mode_t req_mode = oag_pkg::OAG_MODE_REGISTER;
	oag_pkg::oag_instr_t req_instr = oag_pkg::OAG_INSTR_PLAIN_LOAD;
	logic [7:0] req_reg = 8'h00;
	logic req_work4 = 1'b0;
	logic req_pair = 1'b0;
	logic req_short = 1'b0;
	logic [15:0] req_operand = 16'h0000;
	logic [15:0] req_pc = 16'h1000;
	logic [2:0] req_length = 3'h3;
	logic [7:0] register_pointer_zero = 8'h70;
	logic [7:0] register_pointer_one = 8'ha8;
	logic rf_rd_en;
	logic [7:0] rf_rd_addr;
	logic [7:0] rf_rd_data;
	logic rf_wr_en = 1'b0;
	logic [7:0] rf_wr_addr = 8'h00;
	logic [7:0] rf_wr_data = 8'h00;
	logic [7:0] sp_rd_data;
	logic pm_rd_en;
	logic [15:0] pm_rd_addr;
	logic [7:0] pm_rd_data;
	logic ea_valid;
	logic [15:0] ea_addr;
	oag_pkg::oag_space_t ea_space;
	logic ea_error;
	logic stack_push = 1'b0;
	logic stack_pop = 1'b0;
	logic [7:0] stack_addr;
	int n_mismatch = 0;
	int check_count = 0;

	always #50 clk = ~clk;

	oag_top oag_top_inst (.clk, .nrst, .req_valid, .req_ready, .req_mode, .req_instr, .req_reg,
		.req_work4, .req_pair, .req_short, .req_operand, .req_pc, .req_length,
		.register_pointer_zero, .register_pointer_one, .rf_rd_en, .rf_rd_addr, .rf_rd_data,
		.rf_wr_en, .rf_wr_addr, .rf_wr_data, .sp_rd_data, .pm_rd_en, .pm_rd_addr, .pm_rd_data,
		.ea_valid, .ea_addr, .ea_space, .ea_error, .stack_push, .stack_pop, .stack_addr);

	oag_mem_model oag_mem_model_inst (.clk, .rf_rd_en, .rf_rd_addr, .rf_rd_data, .pm_rd_en,
		.pm_rd_addr, .pm_rd_data);

	// ****
	// Tasks
	// ****
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Inputs always move a fixed 5 ns after the rising edge.
	task automatic tick();
		@(posedge clk);
		#5;
	endtask : tick

	task automatic done(input string name);
		$display("test %s done, mismatches so far %0d", name, n_mismatch);
	endtask : done

	task automatic sp_write(input logic [7:0] a, input logic [7:0] d);
		rf_wr_en = 1'b1;
		rf_wr_addr = a;
		rf_wr_data = d;
		tick();
		rf_wr_en = 1'b0;
	endtask : sp_write

	// Strobes are left standing so back-to-back calls in one direction never toggle them in one step.
	task automatic stack(input logic push, input logic [7:0] exp);
		stack_push = push;
		stack_pop = ~push;
		tick();
		check("stack_addr", 16'(stack_addr), 16'(exp));
		check("sp", 16'(sp_rd_data), 16'(push ? exp : exp + 8'h01));
	endtask : stack

	// Flags are {work4, pair, short}; a NONE space without immediate mode means an error.
	task automatic decode(input oag_pkg::oag_mode_t m, input oag_pkg::oag_instr_t i,
		input logic [7:0] r, input logic [2:0] f, input logic [15:0] opnd,
		input logic [15:0] addr, input oag_pkg::oag_space_t sp, input int lat);
		int n;
		logic err;
		err = (sp == oag_pkg::OAG_SPACE_NONE) && (m != oag_pkg::OAG_MODE_IMMEDIATE);
		req_mode = m;
		req_instr = i;
		req_reg = r;
		{req_work4, req_pair, req_short} = f;
		req_operand = opnd;
		n = 0;
		while (req_ready !== 1'b1 && n < 20)
		begin
			tick();
			n++;
		end
		if (req_ready !== 1'b1)
		begin
			$display("ERROR req_ready expected 1 seen timeout");
			n_mismatch++;
			summarize();
		end
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		n = 1;
		while (ea_valid !== 1'b1 && n < 20)
		begin
			tick();
			n++;
		end
		if (ea_valid !== 1'b1)
		begin
			$display("ERROR ea_valid expected 1 seen timeout");
			n_mismatch++;
			summarize();
		end
		else
		begin
			check("ea_error", 16'(ea_error), 16'(err));
			check("ea_space", 16'(ea_space), 16'(sp));
			if (!err)
				check("ea_addr", ea_addr, addr);
			if (lat != 0)
				check("latency", 16'(n), 16'(lat));
		end
	endtask : decode

	// ****
	// Sequence
	// ****
	initial
	begin
		repeat (2) tick();
		nrst = 1'b1;
		repeat (4) tick();

		sp_write(`OAG_SP_ADDR, 8'hff);
		check("sp", 16'(sp_rd_data), 16'h00ff);
		for (int k = 1; k <= 4; k++)
			stack(1'b1, 8'hff - 8'(k));
		for (int k = 4; k >= 1; k--)
			stack(1'b0, 8'hff - 8'(k));
		stack_pop = 1'b0;
		sp_write(`OAG_SP_ADDR, 8'h00);
		stack(1'b1, 8'hff);
		stack_push = 1'b0;
		tick();
		stack_push = 1'b1;
		sp_write(`OAG_SP_ADDR, 8'h40);
		stack_push = 1'b0;
		check("sp", 16'(sp_rd_data), 16'h0040);
		check("stack_addr", 16'(stack_addr), 16'h00ff);
		sp_write(8'hd8, 8'h11);
		check("sp", 16'(sp_rd_data), 16'h0040);
		done("stack");

		decode(oag_pkg::OAG_MODE_REGISTER, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'h06, 3'h4, 16'h0000,
			16'h0076, oag_pkg::OAG_SPACE_REGISTER, 2);
		decode(oag_pkg::OAG_MODE_REGISTER, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'hcb, 3'h0, 16'h0000,
			16'h00ab, oag_pkg::OAG_SPACE_REGISTER, 2);
		decode(oag_pkg::OAG_MODE_REGISTER, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'h41, 3'h2, 16'h0000,
			16'h0000, oag_pkg::OAG_SPACE_NONE, 2);
		decode(oag_pkg::OAG_MODE_REGISTER, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'h40, 3'h2, 16'h0000,
			16'h0040, oag_pkg::OAG_SPACE_REGISTER, 2);
		decode(oag_pkg::OAG_MODE_IMMEDIATE, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'h00, 3'h0,
			16'h0000, 16'h0000, oag_pkg::OAG_SPACE_NONE, 2);
		done("register");

		decode(oag_pkg::OAG_MODE_INDIRECT_REGISTER, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'h30, 3'h0,
			16'h0000, 16'h00b0, oag_pkg::OAG_SPACE_REGISTER, 4);
		decode(oag_pkg::OAG_MODE_INDIRECT_REGISTER, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'h40, 3'h0,
			16'h0000, 16'h0000, oag_pkg::OAG_SPACE_NONE, 4);
		decode(oag_pkg::OAG_MODE_INDIRECT_REGISTER, oag_pkg::OAG_INSTR_PROGRAM_MEMORY_LOAD, 8'h20,
			3'h2, 16'h0000, 16'ha0a1, oag_pkg::OAG_SPACE_PROGRAM, 6);
		decode(oag_pkg::OAG_MODE_INDIRECT_REGISTER, oag_pkg::OAG_INSTR_EXTERNAL_DATA_LOAD, 8'h7e,
			3'h2, 16'h0000, 16'hfeff, oag_pkg::OAG_SPACE_EXTERNAL, 6);
		done("indirect register");

		decode(oag_pkg::OAG_MODE_INDEXED, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'hc9, 3'h0, 16'h0010,
			16'h0039, oag_pkg::OAG_SPACE_REGISTER, 4);
		decode(oag_pkg::OAG_MODE_INDEXED, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'hc9, 3'h0, 16'h0097,
			16'h0000, oag_pkg::OAG_SPACE_NONE, 4);
		decode(oag_pkg::OAG_MODE_INDEXED, oag_pkg::OAG_INSTR_EXTERNAL_DATA_LOAD, 8'hc2, 3'h3,
			16'hab80, 16'hf273, oag_pkg::OAG_SPACE_EXTERNAL, 6);
		decode(oag_pkg::OAG_MODE_INDEXED, oag_pkg::OAG_INSTR_PROGRAM_MEMORY_LOAD, 8'hc2, 3'h2,
			16'h0101, 16'hf3f4, oag_pkg::OAG_SPACE_PROGRAM, 6);
		decode(oag_pkg::OAG_MODE_INDEXED, oag_pkg::OAG_INSTR_ABSOLUTE_JUMP, 8'hc2, 3'h2,
			16'h0101, 16'h0000, oag_pkg::OAG_SPACE_NONE, 2);
		done("indexed");

		decode(oag_pkg::OAG_MODE_DIRECT, oag_pkg::OAG_INSTR_ABSOLUTE_JUMP, 8'h00, 3'h0, 16'h1234,
			16'h1234, oag_pkg::OAG_SPACE_PC, 2);
		decode(oag_pkg::OAG_MODE_DIRECT, oag_pkg::OAG_INSTR_CALL, 8'h00, 3'h0, 16'hffff,
			16'hffff, oag_pkg::OAG_SPACE_PC, 2);
		decode(oag_pkg::OAG_MODE_DIRECT, oag_pkg::OAG_INSTR_EXTERNAL_DATA_LOAD, 8'h00, 3'h0,
			16'h0001, 16'h0001, oag_pkg::OAG_SPACE_EXTERNAL, 2);
		decode(oag_pkg::OAG_MODE_DIRECT, oag_pkg::OAG_INSTR_SHORT_RELATIVE_JUMP, 8'h00, 3'h0,
			16'h0001, 16'h0000, oag_pkg::OAG_SPACE_NONE, 2);
		decode(oag_pkg::OAG_MODE_INDIRECT_ADDRESS, oag_pkg::OAG_INSTR_CALL, 8'h00, 3'h0,
			16'hff40, 16'h1a1b, oag_pkg::OAG_SPACE_PC, 6);
		decode(oag_pkg::OAG_MODE_INDIRECT_ADDRESS, oag_pkg::OAG_INSTR_ABSOLUTE_JUMP, 8'h00, 3'h0,
			16'h0040, 16'h0000, oag_pkg::OAG_SPACE_NONE, 2);
		done("direct and indirect address");

		// The six branch classes follow each other in the instruction enumeration.
		for (int k = 5; k <= 10; k++)
		begin
			decode(oag_pkg::OAG_MODE_RELATIVE, oag_pkg::oag_instr_t'(k), 8'h00, 3'h0, 16'h0080,
				16'h0f83, oag_pkg::OAG_SPACE_PC, 2);
			decode(oag_pkg::OAG_MODE_RELATIVE, oag_pkg::oag_instr_t'(k), 8'h00, 3'h0, 16'h007f,
				16'h1082, oag_pkg::OAG_SPACE_PC, 2);
		end
		decode(oag_pkg::OAG_MODE_RELATIVE, oag_pkg::OAG_INSTR_PLAIN_LOAD, 8'h00, 3'h0, 16'h0010,
			16'h0000, oag_pkg::OAG_SPACE_NONE, 2);
		done("relative");
		summarize();
	end
endmodule : test_operand_address_generator
